/* hdl/irw_pkg.sv */
// Package with register map, field layout, timing and types of the IR wake matcher.
package irw_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;

	// Register offsets.
	localparam logic [7:0] OFS_CONTROL = 8'h13;
	localparam logic [7:0] OFS_WAKE_ADDR = 8'h15;
	localparam logic [7:0] OFS_ADDR_MASK = 8'h16;
	localparam logic [7:0] OFS_RX_ADDR = 8'h17;
	localparam logic [7:0] OFS_RANGE_BASE = 8'h18;
	localparam logic [7:0] OFS_RANGE_LAST = 8'h1F;
	localparam logic [7:0] OFS_WAKE_STATUS = 8'h20;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h21;

	// Control register fields.
	localparam int unsigned CTL_ENABLE = 0;
	localparam int unsigned CTL_INVERT = 2;
	localparam int unsigned CTL_SEL_B = 3;
	localparam int unsigned CTL_PROTO_LO = 4;
	localparam int unsigned CTL_PROTO_HI = 5;
	localparam logic [7:0] CTL_WRITE_MASK = 8'h3D;
	localparam logic [1:0] PROTO_BIPHASE = 2'b00;
	localparam logic [1:0] PROTO_PDIST = 2'b01;

	// Wake status bit for the remote-control event.
	localparam int unsigned STS_IR_EVENT = 5;

	// Reset values.
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_WAKE_ADDR = 8'h00;
	localparam logic [7:0] RST_ADDR_MASK = 8'hE0;
	localparam logic [7:0] RST_RX_ADDR = 8'h00;
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] RST_IRQ_MASK = 8'h00;
	localparam logic [7:0] RST_R0_LO = 8'h10;
	localparam logic [7:0] RST_R0_HI = 8'h14;
	localparam logic [7:0] RST_R1_LO = 8'h07;
	localparam logic [7:0] RST_R1_HI = 8'h0B;
	localparam logic [7:0] RST_R2_LO = 8'h50;
	localparam logic [7:0] RST_R2_HI = 8'h64;
	localparam logic [7:0] RST_R3_LO = 8'h28;
	localparam logic [7:0] RST_R3_HI = 8'h32;
	localparam logic [7:0] DATA_ZERO = 8'h00;

	// Timing: range limits count units of 0.1 ms.
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned UNIT_NS = 100000;
	localparam int unsigned UNIT_CYCLES = (UNIT_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam int unsigned PRE_W = 10;
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(UNIT_CYCLES - 1);
	localparam logic [PRE_W-1:0] PRE_ZERO = 10'h000;
	localparam logic [7:0] DUR_MAX = 8'hFF;
	localparam logic [7:0] DUR_ONE = 8'h01;

	// Frame layout.
	localparam logic [3:0] BIT_ZERO = 4'h0;
	localparam logic [3:0] BIT_ONE = 4'h1;
	localparam logic [3:0] BP_ADDR_FIRST = 4'h4;
	localparam logic [3:0] BP_ADDR_LAST = 4'h8;
	localparam logic [3:0] BP_FRAME_BITS = 4'hE;
	localparam logic [3:0] PD_ADDR_BITS = 4'h8;

	localparam int unsigned NUM_RANGES = 4;
	localparam int unsigned RNG_CELL = 0;
	localparam int unsigned RNG_HALF = 1;
	localparam int unsigned RNG_HDR = 2;
	localparam int unsigned RNG_GAP = 3;

	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} irw_range_s;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_HDR_PULSE = 4'b0010,
		ST_HDR_GAP = 4'b0100,
		ST_DATA = 4'b1000
	} irw_state_e;

endpackage : irw_pkg

/* hdl/irw_range_check.sv */
// Window comparator for one measured duration against one range.
`timescale 1ns/100ps
module irw_range_check (
	// Measured duration in 0.1 ms units.
	input wire logic [7:0] dur_i,
	// Low and high limits.
	input wire irw_pkg::irw_range_s lim_i,
	// Duration lies inside the window.
	output logic hit_o
);
	import irw_pkg::*;

	assign hit_o = (dur_i >= lim_i.low) && (dur_i <= lim_i.high);

endmodule : irw_range_check

/* hdl/irw_matcher.sv */
// Infrared remote wake-up matcher with register file and interrupt.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
// What this block does
// - Control bit 3 clear uses input a, set uses input b.
// - Control bit 2 set inverts the selected infrared input.
// - Enable bit 0 clear keeps registers but blocks the event status flag.
// - The wake enable bit always gates setting the event status flag.
// - Enabled and unmasked address match sets wake status bit 5.
// - Mask bit 0 compares the address bit, mask bit 1 ignores it.
// - Incoming address shifts into read-only received register used for compare.
// - Control, wake address and received address clear to 00h on reset.
// - All range limits count in 0.1 millisecond units.
// - Bi-phase full bit cell must lie within range 0.
// - Pulse-distance interval within range 0 decodes a 0 bit.
// - Bi-phase half cell within range 1; pulse-distance 1 bit within range 1.
// - Pulse-distance header pulse must lie within range 2.
// - Pulse-distance post-header gap must lie within range 3.
module irw_matcher (
	// Clock, reset and enable.
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic soft_reset_i,
	// Register port.
	input wire logic [irw_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [irw_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [irw_pkg::DATA_W-1:0] reg_rdata_o,
	// Infrared receiver inputs.
	input wire logic ir_input_a_i,
	input wire logic ir_input_b_i,
	// Wake event and interrupt.
	output logic ir_event_o,
	output logic irq_o
);
	import irw_pkg::*;

	logic [7:0] ir_wake_control;
	logic [7:0] ir_wake_address;
	logic [7:0] ir_wake_address_mask;
	logic [7:0] ir_received_address;
	logic [7:0] wake_status_0;
	logic [7:0] irq_mask;
	irw_range_s range_lim [NUM_RANGES];
	logic [NUM_RANGES-1:0] range_hit;

	logic ir_selected_input;
	logic ir_level;
	logic ir_prev;
	logic ir_rise;
	logic ir_fall;
	logic ir_edge;
	logic [1:0] proto;
	logic proto_bp;
	logic proto_pd;
	logic enabled;

	logic [PRE_W-1:0] prescale;
	logic [7:0] dur;
	logic restart;

	irw_state_e state;
	irw_state_e next_state;
	logic at_mid;
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	logic capture;
	logic compare;
	logic match;
	logic status_rd;

	// Decoder input path.
	assign enabled = ir_wake_control[CTL_ENABLE];
	assign proto = ir_wake_control[CTL_PROTO_HI:CTL_PROTO_LO];
	assign proto_bp = enabled && (proto == PROTO_BIPHASE);
	assign proto_pd = enabled && (proto == PROTO_PDIST);
	assign ir_selected_input = ir_wake_control[CTL_SEL_B] ?
		ir_input_b_i : ir_input_a_i;
	assign ir_level = ir_selected_input ^ ir_wake_control[CTL_INVERT];
	assign ir_rise = ir_level && !ir_prev;
	assign ir_fall = !ir_level && ir_prev;
	assign ir_edge = ir_rise || ir_fall;

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ir_prev <= 1'b0;
		end else if (ce_i) begin
			ir_prev <= ir_level;
		end
	end

	// Duration measured in 0.1 ms units, restarted at each reference edge.
	assign restart = (state == ST_DATA && proto_pd) ? ir_rise : ir_edge;

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			prescale <= PRE_ZERO;
			dur <= DATA_ZERO;
		end else if (ce_i) begin
			if (restart || state == ST_IDLE) begin
				prescale <= PRE_ZERO;
				dur <= DATA_ZERO;
			end else if (prescale == PRE_LAST) begin
				prescale <= PRE_ZERO;
				if (dur != DUR_MAX) begin
					dur <= dur + DUR_ONE;
				end
			end else begin
				prescale <= prescale + PRE_W'(1);
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_RANGES; gi++) begin : g_range
			irw_range_check u_range (
				.dur_i(dur),
				.lim_i(range_lim[gi]),
				.hit_o(range_hit[gi])
			);
		end
	endgenerate

	// Frame decoder state.
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (ir_rise && proto_pd) begin
					next_state = ST_HDR_PULSE;
				end else if (ir_rise && proto_bp) begin
					next_state = ST_DATA;
				end
			end
			ST_HDR_PULSE: begin
				if (ir_fall) begin
					next_state = range_hit[RNG_HDR] ? ST_HDR_GAP : ST_IDLE;
				end
			end
			ST_HDR_GAP: begin
				if (ir_rise) begin
					next_state = range_hit[RNG_GAP] ? ST_DATA : ST_IDLE;
				end
			end
			ST_DATA: begin
				if (proto_pd && ir_rise) begin
					if (!(range_hit[RNG_CELL] || range_hit[RNG_HALF]) ||
						bit_cnt == PD_ADDR_BITS - BIT_ONE) begin
						next_state = ST_IDLE;
					end
				end else if (proto_bp && ir_edge) begin
					if (!at_mid && !range_hit[RNG_HALF]) begin
						next_state = ST_IDLE;
					end else if (at_mid && !range_hit[RNG_HALF] &&
						!range_hit[RNG_CELL]) begin
						next_state = ST_IDLE;
					end else if (bit_cnt == BP_FRAME_BITS) begin
						next_state = ST_IDLE;
					end
				end
			end
			default: next_state = ST_IDLE;
		endcase
		if (!(proto_bp || proto_pd) || dur == DUR_MAX) begin
			next_state = ST_IDLE;
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= ST_IDLE;
		end else if (ce_i) begin
			state <= soft_reset_i ? ST_IDLE : next_state;
		end
	end

	// Bit recovery and address shifting.
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			at_mid <= 1'b0;
			bit_cnt <= BIT_ZERO;
			shift <= DATA_ZERO;
			capture <= 1'b0;
		end else if (ce_i) begin
			capture <= 1'b0;
			// A valid period goes first so the closing period still captures.
			if (state == ST_DATA && proto_pd && ir_rise &&
				(range_hit[RNG_CELL] || range_hit[RNG_HALF])) begin
				shift <= {range_hit[RNG_HALF] && !range_hit[RNG_CELL],
					shift[7:1]};
				bit_cnt <= bit_cnt + BIT_ONE;
				if (bit_cnt == PD_ADDR_BITS - BIT_ONE) begin
					capture <= 1'b1;
				end
			end else if (state == ST_IDLE || next_state == ST_IDLE) begin
				at_mid <= 1'b1;
				bit_cnt <= (state == ST_IDLE && !proto_pd) ? BIT_ONE :
					BIT_ZERO;
				if (state == ST_IDLE) begin
					shift <= DATA_ZERO;
				end
			end else if (state == ST_DATA && proto_bp && ir_edge) begin
				if (at_mid && range_hit[RNG_HALF]) begin
					at_mid <= 1'b0;
				end else begin
					// Full cell from mid to mid, or half from edge to mid.
					at_mid <= 1'b1;
					bit_cnt <= bit_cnt + BIT_ONE;
					if (bit_cnt + BIT_ONE >= BP_ADDR_FIRST &&
						bit_cnt + BIT_ONE <= BP_ADDR_LAST) begin
						shift <= {shift[6:0], ir_level};
					end
					if (bit_cnt + BIT_ONE == BP_ADDR_LAST) begin
						capture <= 1'b1;
					end
				end
			end
		end
	end

	// Received address register and compare one cycle after capture.
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ir_received_address <= RST_RX_ADDR;
			compare <= 1'b0;
		end else if (ce_i) begin
			compare <= capture && !soft_reset_i;
			if (soft_reset_i) begin
				ir_received_address <= RST_RX_ADDR;
			end else if (capture) begin
				ir_received_address <= shift;
			end
		end
	end

	assign match = compare && (((ir_received_address ^ ir_wake_address) &
		~ir_wake_address_mask) == DATA_ZERO);

	// Software registers.
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ir_wake_control <= RST_CONTROL;
			ir_wake_address <= RST_WAKE_ADDR;
			ir_wake_address_mask <= RST_ADDR_MASK;
			irq_mask <= RST_IRQ_MASK;
			range_lim[RNG_CELL] <= {RST_R0_HI, RST_R0_LO};
			range_lim[RNG_HALF] <= {RST_R1_HI, RST_R1_LO};
			range_lim[RNG_HDR] <= {RST_R2_HI, RST_R2_LO};
			range_lim[RNG_GAP] <= {RST_R3_HI, RST_R3_LO};
		end else if (ce_i) begin
			if (soft_reset_i) begin
				ir_wake_control <= RST_CONTROL;
				ir_wake_address <= RST_WAKE_ADDR;
				ir_wake_address_mask <= RST_ADDR_MASK;
				irq_mask <= RST_IRQ_MASK;
				range_lim[RNG_CELL] <= {RST_R0_HI, RST_R0_LO};
				range_lim[RNG_HALF] <= {RST_R1_HI, RST_R1_LO};
				range_lim[RNG_HDR] <= {RST_R2_HI, RST_R2_LO};
				range_lim[RNG_GAP] <= {RST_R3_HI, RST_R3_LO};
			end else if (reg_wr_i) begin
				case (reg_addr_i)
					OFS_CONTROL: ir_wake_control <= reg_wdata_i & CTL_WRITE_MASK;
					OFS_WAKE_ADDR: ir_wake_address <= reg_wdata_i;
					OFS_ADDR_MASK: ir_wake_address_mask <= reg_wdata_i;
					OFS_IRQ_MASK: irq_mask <= reg_wdata_i;
					default: begin
						if (reg_addr_i >= OFS_RANGE_BASE &&
							reg_addr_i <= OFS_RANGE_LAST) begin
							if (reg_addr_i[0]) begin
								range_lim[reg_addr_i[2:1]].high <= reg_wdata_i;
							end else begin
								range_lim[reg_addr_i[2:1]].low <= reg_wdata_i;
							end
						end
					end
				endcase
			end
		end
	end

	// Sticky wake status; a read clears it but a new event wins.
	assign status_rd = reg_rd_i && (reg_addr_i == OFS_WAKE_STATUS);

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wake_status_0 <= RST_STATUS;
		end else if (ce_i) begin
			if (soft_reset_i) begin
				wake_status_0 <= RST_STATUS;
			end else if (match && enabled) begin
				wake_status_0[STS_IR_EVENT] <= 1'b1;
			end else if (status_rd) begin
				wake_status_0 <= RST_STATUS;
			end
		end
	end

	assign ir_event_o = wake_status_0[STS_IR_EVENT];
	assign irq_o = |(wake_status_0 & irq_mask);

	// Read data, valid in the cycle after the read strobe.
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reg_rdata_o <= DATA_ZERO;
		end else if (ce_i) begin
			reg_rdata_o <= DATA_ZERO;
			if (reg_rd_i) begin
				case (reg_addr_i)
					OFS_CONTROL: reg_rdata_o <= ir_wake_control;
					OFS_WAKE_ADDR: reg_rdata_o <= ir_wake_address;
					OFS_ADDR_MASK: reg_rdata_o <= ir_wake_address_mask;
					OFS_RX_ADDR: reg_rdata_o <= ir_received_address;
					OFS_WAKE_STATUS: reg_rdata_o <= wake_status_0;
					OFS_IRQ_MASK: reg_rdata_o <= irq_mask;
					default: begin
						if (reg_addr_i >= OFS_RANGE_BASE &&
							reg_addr_i <= OFS_RANGE_LAST) begin
							reg_rdata_o <= reg_addr_i[0] ?
								range_lim[reg_addr_i[2:1]].high :
								range_lim[reg_addr_i[2:1]].low;
						end
					end
				endcase
			end
		end
	end

endmodule : irw_matcher

/* tb/irw_ir_source.sv */
// Infrared receiver model: pulse-distance frames on input b, bi-phase on a.
`timescale 1ns/100ps
module irw_ir_source (
	// Clock.
	input wire logic core_clk_i,
	// Receiver outputs, pulses are low on input b and high on input a.
	output logic ir_input_a_o,
	output logic ir_input_b_o
);
	initial begin
		ir_input_a_o = 1'b0;
		ir_input_b_o = 1'b1;
	end
	task automatic hold(input logic lvl, input int cyc);
		ir_input_b_o <= ~lvl;
		repeat (cyc) @(posedge core_clk_i);
	endtask : hold
	task automatic frame(input logic [7:0] addr);
		hold(1'b1, 2100);
		hold(1'b0, 2100);
		for (int i = 0; i < 8; i++) begin
			hold(1'b1, 500);
			hold(1'b0, addr[i] ? 1600 : 600);
		end
		hold(1'b1, 500);
		hold(1'b0, 20);
		#1;
	endtask : frame
	// Bi-phase frame on input a, first bit in the top position.
	task automatic biphase(input logic [13:0] bits);
		for (int i = 13; i >= 0; i--) begin
			ir_input_a_o <= ~bits[i];
			repeat (1100) @(posedge core_clk_i);
			ir_input_a_o <= bits[i];
			repeat (1100) @(posedge core_clk_i);
		end
		ir_input_a_o <= 1'b0;
		repeat (20) @(posedge core_clk_i);
		#1;
	endtask : biphase
endmodule : irw_ir_source

/* tb/irw_matcher_assertions.sv */
// Checker with concurrent assertions on the IR wake matcher ports.
`timescale 1ns/100ps
module irw_matcher_checker (
	// Clock, reset and enable.
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic soft_reset_i,
	// Register port.
	input wire logic [irw_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [irw_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [irw_pkg::DATA_W-1:0] reg_rdata_o,
	// Infrared inputs and outputs.
	input wire logic ir_input_a_i,
	input wire logic ir_input_b_i,
	input wire logic ir_event_o,
	input wire logic irq_o
);
	import irw_pkg::*;
	logic [7:0] ctl;
	logic msk5;
	logic [2:0] quiet;
	logic [1:0] pins_prev;
	logic wr_go;
	logic rd_sts;
	assign wr_go = reg_wr_i && ce_i;
	assign rd_sts = reg_rd_i && ce_i && reg_addr_i == OFS_WAKE_STATUS;
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctl <= RST_CONTROL;
			msk5 <= 1'b0;
		end else if (ce_i && soft_reset_i) begin
			ctl <= RST_CONTROL;
			msk5 <= 1'b0;
		end else if (wr_go && reg_addr_i == OFS_CONTROL) begin
			ctl <= reg_wdata_i & CTL_WRITE_MASK;
		end else if (wr_go && reg_addr_i == OFS_IRQ_MASK) begin
			msk5 <= reg_wdata_i[STS_IR_EVENT];
		end
	end
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pins_prev <= 2'h0;
			quiet <= 3'h7;
		end else begin
			pins_prev <= {ir_input_a_i, ir_input_b_i};
			if (pins_prev != {ir_input_a_i, ir_input_b_i}) begin
				quiet <= 3'h0;
			end else if (quiet != 3'h7) begin
				quiet <= quiet + 3'h1;
			end
		end
	end
	default clocking dc @(posedge core_clk_i);
	endclocking
	default disable iff (!reset_n_i);
	chk_ctl_readback: assert property (reg_rd_i && ce_i &&
		reg_addr_i == OFS_CONTROL |=> reg_rdata_o == ctl)
		else $error("control read data differs");
	chk_event_enable: assert property ($rose(ir_event_o) |->
		ctl[CTL_ENABLE] && !ctl[CTL_PROTO_HI])
		else $error("event set while disabled");
	chk_event_edge: assert property ($rose(ir_event_o) |->
		quiet inside {[1:5]})
		else $error("event not tied to a pin edge");
	chk_event_sticky: assert property (ir_event_o && !rd_sts &&
		!(ce_i && soft_reset_i) |=> ir_event_o)
		else $error("event dropped without read");
	chk_status_clear: assert property (rd_sts && quiet == 3'h7
		|=> !ir_event_o)
		else $error("status read did not clear");
	chk_status_read: assert property (rd_sts && ir_event_o
		|=> reg_rdata_o[STS_IR_EVENT])
		else $error("status read lost event bit");
	chk_irq_level: assert property (irq_o == (ir_event_o && msk5))
		else $error("irq level wrong");
	chk_soft_clear: assert property (ce_i && soft_reset_i
		|=> !ir_event_o && !irq_o)
		else $error("soft reset left event");
	cover property ($rose(ir_event_o));
	cover property (irq_o);
	cover property (rd_sts && ir_event_o);
	cover property ($rose(ir_event_o) && !ctl[CTL_PROTO_LO]);
endmodule : irw_matcher_checker
bind irw_matcher irw_matcher_checker u_chk (
	.core_clk_i(core_clk_i),
	.reset_n_i(reset_n_i),
	.ce_i(ce_i),
	.soft_reset_i(soft_reset_i),
	.reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i),
	.reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o),
	.ir_input_a_i(ir_input_a_i),
	.ir_input_b_i(ir_input_b_i),
	.ir_event_o(ir_event_o),
	.irq_o(irq_o)
);

/* tb/tb_irw_matcher.sv */
// Testbench for the IR wake matcher.
`timescale 1ns/100ps
module tb_irw_matcher;
	import irw_pkg::*;
	logic core_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic soft_reset_i = 1'b0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic [7:0] reg_rdata_o;
	logic ir_a, ir_b, ir_event_o, irq_o;
	int num_errors = 0;
	int tests_run = 0;
	logic [7:0] rst_rng [8] = '{8'h10, 8'h14, 8'h07, 8'h0B, 8'h50, 8'h64,
		8'h28, 8'h32};
	logic [7:0] new_rng [8] = '{8'h01, 8'h01, 8'h02, 8'h02, 8'h02, 8'h02,
		8'h02, 8'h02};
	logic [7:0] bp_rng [4] = '{8'h02, 8'h02, 8'h01, 8'h01};
	always #50 core_clk_i = ~core_clk_i;
	irw_ir_source src (
		.core_clk_i(core_clk_i),
		.ir_input_a_o(ir_a),
		.ir_input_b_o(ir_b)
	);
	irw_matcher dut (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.ce_i(1'b1),
		.soft_reset_i(soft_reset_i),
		.reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o),
		.ir_input_a_i(ir_a),
		.ir_input_b_i(ir_b),
		.ir_event_o(ir_event_o),
		.irq_o(irq_o)
	);
	task automatic check(input string what, input logic [7:0] exp, act);
		tests_run++;
		if (act !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, act);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, d);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, exp, input string what);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		check(what, exp, reg_rdata_o);
	endtask : rd
	task automatic summarize;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize
	initial begin
		repeat (90000) @(posedge core_clk_i);
		num_errors++;
		summarize();
	end
	initial begin
		repeat (12) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		rd(OFS_CONTROL, 8'h00, "control");
		rd(OFS_WAKE_ADDR, 8'h00, "wake addr");
		rd(OFS_ADDR_MASK, 8'hE0, "mask");
		rd(OFS_RX_ADDR, 8'h00, "rx addr");
		for (int i = 0; i < 8; i++) begin
			rd(OFS_RANGE_BASE + 8'(i), rst_rng[i], "range");
			wr(OFS_RANGE_BASE + 8'(i), new_rng[i]);
		end
		wr(OFS_CONTROL, 8'hFF);
		rd(OFS_CONTROL, 8'h3D, "control");
		wr(OFS_RX_ADDR, 8'h55);
		rd(OFS_RX_ADDR, 8'h00, "rx addr");
		wr(8'h30, 8'h55);
		rd(8'h30, 8'h00, "unmapped");
		wr(OFS_CONTROL, 8'h1D);
		wr(OFS_WAKE_ADDR, 8'hA5);
		wr(OFS_ADDR_MASK, 8'h01);
		wr(OFS_IRQ_MASK, 8'h20);
		src.frame(8'hA4);
		check("event", 8'h01, {7'h00, ir_event_o});
		check("irq", 8'h01, {7'h00, irq_o});
		wr(OFS_IRQ_MASK, 8'h00);
		check("irq", 8'h00, {7'h00, irq_o});
		rd(OFS_RX_ADDR, 8'hA4, "rx addr");
		rd(OFS_WAKE_STATUS, 8'h20, "status");
		rd(OFS_WAKE_STATUS, 8'h00, "status");
		wr(OFS_IRQ_MASK, 8'h20);
		src.frame(8'hB4);
		rd(OFS_RX_ADDR, 8'hB4, "rx addr");
		check("event", 8'h00, {7'h00, ir_event_o});
		wr(OFS_CONTROL, 8'h1C);
		src.frame(8'hA5);
		rd(OFS_RX_ADDR, 8'hB4, "rx addr");
		check("event", 8'h00, {7'h00, ir_event_o});
		rd(OFS_CONTROL, 8'h1C, "control");
		@(posedge core_clk_i);
		soft_reset_i <= 1'b1;
		@(posedge core_clk_i);
		soft_reset_i <= 1'b0;
		rd(OFS_CONTROL, 8'h00, "control");
		rd(OFS_WAKE_ADDR, 8'h00, "wake addr");
		for (int i = 0; i < 4; i++) begin
			wr(OFS_RANGE_BASE + 8'(i), bp_rng[i]);
		end
		wr(OFS_WAKE_ADDR, 8'h15);
		wr(OFS_CONTROL, 8'h01);
		src.biphase(14'h3541);
		rd(OFS_RX_ADDR, 8'h15, "rx addr");
		check("event", 8'h01, {7'h00, ir_event_o});
		summarize();
	end
endmodule : tb_irw_matcher
